/* File: core/cpu_instruction_timing.sv */
// Instruction decode and cycle timing control for the pipelined 8-bit core
// Operation
// - Timing counted only in system clock cycles
// - Most instructions take cycles equal to bytes
// - Untaken conditional branch takes one cycle less
// - ALU with working register: 1 byte, 1 cycle
// - ALU with indirect RAM: 1 byte, 2 cycles
// - ALU with direct byte: 2 bytes, 2 cycles
// - ALU with immediate: 2 bytes, 2 cycles
// - Logic immediate into direct: 3 bytes, 3 cycles
// - Load data pointer immediate: 3 bytes, 3 cycles
// - Code byte reads: 1 byte, 3 cycles
// - External data moves: 1 byte, 3 cycles
// - Push and pop: 2 bytes, 2 cycles
// - Direct-to-direct and immediate-to-direct: 3 bytes, 3 cycles
// - Stores through index register take 2 cycles
// - Low nibble exchange: 1 byte, 2 cycles
// - Working register exchange: 1 byte, 1 cycle
// - Accumulator-only operations: 1 byte, 1 cycle
// - Carry and direct bit operations: 2 bytes, 2 cycles
// - Jump-if-set-and-clear: 3 bytes, 3/4, clears bit
// - Indirect jump via data pointer: 1 byte, 3 cycles
// - Spare opcode behaves as no-operation
`timescale 1ns/10ps
`include "cpu_timing_consts.svh"

module cpu_instruction_timing (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Opcode fetch
  input  wire logic                        op_valid,
  input  wire logic [7:0]                  op_byte,
  output logic                             op_ready,
  // Branch condition from the datapath, valid with the opcode
  input  wire logic                        branch_taken,
  // Issue and retire
  output cpu_timing_pkg::instr_info_t      issue_info,
  output logic                             busy,
  output logic                             retire,
  output cpu_timing_pkg::instr_info_t      retire_info
);

  // Length and base cycle count for every opcode, laid out by low nibble
  function automatic cpu_timing_pkg::instr_info_t decode(input logic [7:0] op,
                                                         input logic       tk);
    cpu_timing_pkg::instr_info_t d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic [1:0] l;
    logic [3:0] c;
    logic       cd;
    hi = op[7:4];
    lo = op[3:0];
    l  = 2'h1;
    c  = 4'h1;
    cd = 1'b0;
    if (lo[3]) begin
      // Working register column
      case (hi)
        4'h7, 4'h8, 4'hA: begin l = 2'h2; c = 4'h2; end
        4'hB:             begin l = 2'h3; c = 4'h3; cd = 1'b1; end
        4'hD:             begin l = 2'h2; c = 4'h2; cd = 1'b1; end
        default:          begin l = 2'h1; c = 4'h1; end
      endcase
    end else begin
      case (lo)
        4'h6, 4'h7: begin
          // Index register indirect column
          case (hi)
            4'h7, 4'h8, 4'hA: begin l = 2'h2; c = 4'h2; end
            4'hB:             begin l = 2'h3; c = 4'h4; cd = 1'b1; end
            default:          begin l = 2'h1; c = 4'h2; end
          endcase
        end
        4'h5: begin
          case (hi)
            4'h7, 4'h8: begin l = 2'h3; c = 4'h3; end
            4'hA:       begin l = 2'h1; c = 4'h1; end
            4'hB, 4'hD: begin l = 2'h3; c = 4'h3; cd = 1'b1; end
            default:    begin l = 2'h2; c = 4'h2; end
          endcase
        end
        4'h4: begin
          case (hi)
            4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: begin l = 2'h1; c = 4'h1; end
            4'h8:    begin l = 2'h1; c = 4'h8; end
            4'hA:    begin l = 2'h1; c = 4'h4; end
            4'hB:    begin l = 2'h3; c = 4'h3; cd = 1'b1; end
            default: begin l = 2'h2; c = 4'h2; end
          endcase
        end
        4'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: begin l = 2'h3; c = 4'h3; end
            4'h7, 4'h8, 4'h9, 4'hE, 4'hF: begin
              l = 2'h1;
              c = 4'h3;
            end
            default: begin l = 2'h1; c = 4'h1; end
          endcase
        end
        4'h2: begin
          case (hi)
            4'h0, 4'h1: begin l = 2'h3; c = 4'h4; end
            4'h2, 4'h3: begin l = 2'h1; c = 4'h5; end
            4'hE, 4'hF: begin l = 2'h1; c = 4'h3; end
            default:    begin l = 2'h2; c = 4'h2; end
          endcase
        end
        4'h1: begin
          l = 2'h2;
          c = 4'h3;
        end
        default: begin
          // Column 0: relative jumps, bit ops, stack, pointer loads
          case (hi)
            4'h0:                   begin l = 2'h1; c = 4'h1; end
            4'h1, 4'h2, 4'h3:       begin l = 2'h3; c = 4'h3; cd = 1'b1; end
            4'h4, 4'h5, 4'h6, 4'h7: begin l = 2'h2; c = 4'h2; cd = 1'b1; end
            4'h8:                   begin l = 2'h2; c = 4'h3; end
            4'h9:                   begin l = 2'h3; c = 4'h3; end
            4'hE, 4'hF:             begin l = 2'h1; c = 4'h3; end
            default:                begin l = 2'h2; c = 4'h2; end
          endcase
        end
      endcase
    end
    d.opcode  = op;
    d.len     = l;
    // Taken conditional branches spend one more cycle
    d.cycles  = (cd && tk) ? c + `CT_BR_EXTRA : c;
    d.cond    = cd;
    d.taken   = cd && tk;
    d.clr_bit = (op == `CT_BIT_CLR_OP);
    return d;
  endfunction

  cpu_timing_pkg::phase_t      phase_r;
  logic [`CT_CYC_W-1:0]        cnt_r;
  cpu_timing_pkg::instr_info_t cur_r;
  logic                        retire_r;
  cpu_timing_pkg::instr_info_t dec;
  cpu_timing_pkg::instr_info_t dec_nt;
  logic                        accept;

  assign dec    = decode(op_byte, branch_taken);
  // Same opcode judged as not taken, checker helper
  assign dec_nt = decode(op_byte, 1'b0);
  // Fetch is held off until the running instruction used all its cycles
  assign op_ready = (cnt_r == '0);
  assign accept   = op_valid && op_ready;
  assign busy     = (phase_r == cpu_timing_pkg::PH_EXEC);
  assign issue_info  = cur_r;
  assign retire      = retire_r;
  assign retire_info = cur_r;

  // Remaining cycles of the running instruction, in clock cycles only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (accept) begin
      cnt_r <= dec.cycles - 4'h1;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Latched instruction description
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_r <= '0;
    end else if (accept) begin
      cur_r <= dec;
    end
  end

  // Phase tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= cpu_timing_pkg::PH_IDLE;
    end else begin
      case (phase_r)
        cpu_timing_pkg::PH_IDLE: begin
          if (accept && dec.cycles != 4'h1) begin
            phase_r <= cpu_timing_pkg::PH_EXEC;
          end
        end
        cpu_timing_pkg::PH_EXEC: begin
          if (cnt_r == 4'h1) begin
            phase_r <= cpu_timing_pkg::PH_IDLE;
          end
        end
        default: phase_r <= cpu_timing_pkg::PH_IDLE;
      endcase
    end
  end

  // Retire pulse after the last cycle of each instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      retire_r <= 1'b0;
    end else begin
      retire_r <= (accept && dec.cycles == 4'h1) || (cnt_r == 4'h1);
    end
  end

  // Cycles spent since issue, checker helper
  logic [3:0] span_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      span_r <= '0;
    end else if (accept) begin
      span_r <= 4'h1;
    end else if (span_r != 4'hF) begin
      span_r <= span_r + 4'h1;
    end
  end

  chk_span_match: assert property (@(posedge clk) disable iff (rst)
    retire |-> span_r == cur_r.cycles)
    else $error("retire time differs from decoded cycle count");

  chk_hold_issue: assert property (@(posedge clk) disable iff (rst)
    accept && dec.cycles > 4'h1 |=> !op_ready ##0 (cnt_r == $past(dec.cycles) - 4'h1))
    else $error("fetch not held off during multi-cycle instruction");

  chk_branch_extra: assert property (@(posedge clk) disable iff (rst)
    accept && dec.cond |-> dec.cycles == dec_nt.cycles + (branch_taken ? 4'h1 : 4'h0))
    else $error("branch taken and untaken differ by other than one cycle");

  chk_reg_alu: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[3] && op_byte[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
      |-> dec.len == 2'h1 && dec.cycles == 4'h1)
    else $error("working register ALU op not 1 byte 1 cycle");

  chk_ind_alu: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[3:1] == 3'h3 && op_byte[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
      |-> dec.len == 2'h1 && dec.cycles == 4'h2)
    else $error("indirect ALU op not 1 byte 2 cycles");

  chk_ext_moves: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[7:5] == 3'h7 && op_byte[3:2] == 2'h0 && op_byte[1:0] != 2'h1
      |=> !retire ##1 !retire ##1 retire)
    else $error("external data move not retired after 3 cycles");

  chk_spare_nop: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte == `CT_SPARE_OP |=> retire && op_ready)
    else $error("spare opcode not handled as no-operation");

  chk_bit_clear: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte == `CT_BIT_CLR_OP
      |-> dec.len == 2'h3 && dec.cycles == (branch_taken ? 4'h4 : 4'h3) && dec.clr_bit)
    else $error("jump-if-set-and-clear timing or clear flag wrong");

  chk_len_eq_cyc: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte inside {8'h75, 8'h85, 8'h90, 8'h43, 8'hC0, 8'hD0, 8'hE8}
      |-> dec.cycles == {2'h0, dec.len})
    else $error("cycles differ from byte length");

  // Opcode class checks, figures written out independently of the table
  chk_alu_direct: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[3:0] == 4'h5 && op_byte[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
      |-> dec.len == 2'h2 && dec.cycles == 4'h2)
    else $error("direct operand ALU op not 2 bytes 2 cycles");

  chk_alu_imm: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[3:0] == 4'h4 && op_byte[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}
      |-> dec.len == 2'h2 && dec.cycles == 4'h2)
    else $error("immediate ALU op not 2 bytes 2 cycles");

  chk_logic_imm: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte inside {8'h43, 8'h53, 8'h63}
      |-> dec.len == 2'h3 && dec.cycles == 4'h3)
    else $error("logic immediate into direct not 3 bytes 3 cycles");

  chk_data_pointer16_load: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte == 8'h90
      |-> dec.len == 2'h3 ##1 !retire ##1 !retire ##1 retire)
    else $error("data pointer load not retired after 3 cycles");

  chk_code_read: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte inside {8'h73, 8'h83, 8'h93}
      |-> dec.len == 2'h1 ##1 !retire ##1 !retire ##1 retire)
    else $error("code read or indirect jump not 1 byte 3 cycles");

  chk_push_pop: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte inside {8'hC0, 8'hD0}
      |-> dec.len == 2'h2 ##1 !retire ##1 retire)
    else $error("stack push or pop not 2 bytes 2 cycles");

  chk_direct_move: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte inside {8'h75, 8'h85}
      |-> dec.len == 2'h3 && dec.cycles == 4'h3)
    else $error("move into direct byte not 3 bytes 3 cycles");

  chk_ind_store: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[7:1] inside {7'h3B, 7'h53, 7'h7B}
      |-> dec.cycles == 4'h2 && (op_byte[7:4] != 4'hF || dec.len == 2'h1))
    else $error("indirect store not 2 cycles");

  chk_nibble_xchg: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[7:1] == 7'h6B
      |-> dec.len == 2'h1 && dec.cycles == 4'h2)
    else $error("low nibble exchange not 1 byte 2 cycles");

  chk_reg_xchg: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte[7:3] == 5'h19
      |-> dec.len == 2'h1 && dec.cycles == 4'h1)
    else $error("working register exchange not 1 byte 1 cycle");

  chk_acc_only: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte inside {8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4, 8'hF4}
      |-> dec.len == 2'h1 && dec.cycles == 4'h1)
    else $error("accumulator-only op not 1 byte 1 cycle");

  chk_bit_ops: assert property (@(posedge clk) disable iff (rst)
    accept && op_byte inside {8'h72, 8'hA0, 8'h82, 8'hB0, 8'hA2, 8'h92, 8'hB2, 8'hC2, 8'hD2}
      |-> dec.len == 2'h2 && dec.cycles == 4'h2)
    else $error("carry or direct bit op not 2 bytes 2 cycles");

  chk_single_cycle: assert property (@(posedge clk) disable iff (rst)
    accept && dec.cycles == 4'h1
      |=> retire && op_ready && !busy)
    else $error("single-cycle op did not retire on the next cycle");

  chk_busy_ready: assert property (@(posedge clk) disable iff (rst)
    busy
      |-> !op_ready)
    else $error("fetch offered while an instruction is still running");

  chk_issue_latch: assert property (@(posedge clk) disable iff (rst)
    accept
      |=> issue_info == $past(dec))
    else $error("issued description differs from the accepted opcode");

  cov_single: cover property (@(posedge clk) disable iff (rst)
    accept && dec.cycles == 4'h1 ##1 accept);
  cov_taken: cover property (@(posedge clk) disable iff (rst)
    accept && dec.cond && branch_taken);
  cov_untaken: cover property (@(posedge clk) disable iff (rst)
    accept && dec.cond && !branch_taken);
  cov_longest: cover property (@(posedge clk) disable iff (rst)
    retire && retire_info.cycles == 4'h8);
  cov_chained_long: cover property (@(posedge clk) disable iff (rst)
    retire && accept && dec.cycles > 4'h1);

endmodule // cpu_instruction_timing

/* File: core/cpu_timing_consts.svh */
// Timing and opcode constants for the instruction timing controller
`ifndef CPU_TIMING_CONSTS_SVH
`define CPU_TIMING_CONSTS_SVH

// Width of the cycle count field; the longest instruction takes 8 cycles
`define CT_CYC_W       4
// Width of the byte length field; the longest instruction is 3 bytes
`define CT_LEN_W       2
// Extra cycle a conditional branch spends when it is taken
`define CT_BR_EXTRA    4'h1
// Opcodes with special meaning
`define CT_NOP_OP      8'h00
`define CT_SPARE_OP    8'hA5
`define CT_BIT_CLR_OP  8'h10
// Clock figures: 250 MHz core clock, period in ns
`define CT_CLK_MHZ     250
`define CT_CLK_NS      4

`endif

/* File: core/cpu_timing_pkg.sv */
// Types shared by the instruction timing controller
package cpu_timing_pkg;

  // One decoded instruction as it is issued and retired
  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] len;      // program bytes
    logic [3:0] cycles;   // clock cycles actually spent
    logic       cond;     // conditional branch
    logic       taken;    // branch condition was true
    logic       clr_bit;  // tested bit is cleared
  } instr_info_t;

  // Controller phase
  typedef enum logic [0:0] {
    PH_IDLE,
    PH_EXEC
  } phase_t;

endpackage

/* File: test/prog_mem_model.sv */
// Opcode fetch source standing in for program memory
`timescale 1ns/10ps

module prog_mem_model (
  // Clock
  input  wire logic       clk,
  // Opcode fetch
  output logic            op_valid,
  output logic [7:0]      op_byte,
  output logic            branch_taken,
  input  wire logic       op_ready
);

  initial begin
    op_valid     = 1'b0;
    op_byte      = 8'h00;
    branch_taken = 1'b0;
  end

  // Released lines never keep the old value, so a stale sample cannot pass
  task automatic go_idle();
    op_valid     = 1'b0;
    op_byte      = ~op_byte;
    branch_taken = ~branch_taken;
  endtask

  // Returns at the falling edge before the taking rising edge
  task automatic offer(input logic [7:0] op, input logic tk, input int gap, output bit ok);
    ok = 1'b0;
    @(negedge clk);
    repeat (gap) begin
      go_idle();
      @(negedge clk);
    end
    op_valid     = 1'b1;
    op_byte      = op;
    branch_taken = tk;
    for (int k = 0; k < 16; k++) begin
      if (op_ready === 1'b1) begin
        ok = 1'b1;
        break;
      end
      @(negedge clk);
    end
  endtask

endmodule // prog_mem_model

/* File: test/tb_top.sv */
// Self-checking bench for the instruction timing controller
`timescale 1ns/10ps

module tb_top;
  typedef struct {
    cpu_timing_pkg::instr_info_t info;
    int                          due;
  } note_t;

  logic                        clk;
  logic                        rst;
  logic                        op_valid;
  logic [7:0]                  op_byte;
  logic                        op_ready;
  logic                        branch_taken;
  cpu_timing_pkg::instr_info_t issue_info;
  logic                        busy;
  logic                        retire;
  cpu_timing_pkg::instr_info_t retire_info;
  int                          n_fail = 0;
  int                          num_checks = 0;
  int                          cyc = 0;
  int                          last_take = 0;
  int                          last_due = 0;
  int                          seed;
  note_t                       notes[$];
  // Opcode, bytes, cycles, flags {conditional, clears bit}
  logic [19:0]                 tab[32] = '{
    20'h28110, 20'h26120, 20'h25220, 20'h24220,
    20'h53330, 20'h90330, 20'h93130, 20'h83130,
    20'hE2130, 20'hF0130, 20'hC0220, 20'hD0220,
    20'h85330, 20'h75330, 20'hF6120, 20'hD6120,
    20'hC8110, 20'hE4110, 20'hF4110, 20'h23110,
    20'h33110, 20'h03110, 20'h13110, 20'hC4110,
    20'h82220, 20'hD2220, 20'h10333, 20'h73130,
    20'hA5110, 20'h00110, 20'h40222, 20'hF2130
  };

  cpu_instruction_timing i_dut (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready),
    .branch_taken(branch_taken), .issue_info(issue_info), .busy(busy), .retire(retire),
    .retire_info(retire_info)
  );

  prog_mem_model i_mem (
    .clk(clk), .op_valid(op_valid), .op_byte(op_byte), .branch_taken(branch_taken),
    .op_ready(op_ready)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Releases the fetch lines and waits, bounded, for every noted retire
  task automatic drain();
    @(negedge clk);
    i_mem.go_idle();
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(negedge clk);
    if (notes.size() != 0) begin
      n_fail++;
    end
  endtask

  // Expectation is noted at the falling edge before the taking edge
  task automatic run(input logic [19:0] e, input logic tk, input int gap);
    note_t n;
    bit    ok;
    n.info.opcode  = e[19:12];
    n.info.len     = e[9:8];
    n.info.cycles  = e[7:4] + ((e[1] && tk) ? 4'h1 : 4'h0);
    n.info.cond    = e[1];
    n.info.taken   = tk;
    n.info.clr_bit = e[0];
    i_mem.offer(n.info.opcode, tk, gap, ok);
    n.due = cyc + int'(n.info.cycles);
    last_take = cyc;
    last_due  = n.due;
    if (!ok) begin
      n_fail++;
      end_sim();
    end
    notes.push_back(n);
  endtask

  always @(negedge clk) begin
    note_t n;
    // Busy stands from the edge after the take up to the retire cycle
    if (rst === 1'b0) begin
      check("busy", 32'(cyc > last_take && cyc < last_due), 32'(busy));
    end
    if (rst === 1'b0 && retire === 1'b1) begin
      if (notes.size() == 0) begin
        check("retire without issue", 32'h0, 32'h1);
      end else begin
        n = notes.pop_front();
        check("retire cycle", n.due, cyc);
        check("opcode", 32'(n.info.opcode), 32'(retire_info.opcode));
        check("bytes", 32'(n.info.len), 32'(retire_info.len));
        check("cycles", 32'(n.info.cycles), 32'(retire_info.cycles));
        check("flags", 32'({n.info.cond, n.info.clr_bit}),
              32'({retire_info.cond, retire_info.clr_bit}));
        if (n.info.cond) check("taken", 32'(n.info.taken), 32'(retire_info.taken));
        check("ready at retire", 32'h1, 32'(op_ready));
        check("issue opcode", 32'(n.info.opcode), 32'(issue_info.opcode));
      end
    end
  end

  initial begin
    rst  = 1'b1;
    seed = 32'h67303724;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (tab[i]) run(tab[i], 1'b0, 0);
    foreach (tab[i]) run(tab[i], 1'b1, 1);
    // Random mix of back-to-back and spaced opcodes
    repeat (300) run(tab[$unsigned($random(seed)) % 32], 1'($random(seed)),
                     $unsigned($random(seed)) % 3);
    drain();
    // Reset while a multi-cycle instruction is in flight
    run(tab[5], 1'b0, 0);
    @(negedge clk);
    rst       = 1'b1;
    last_take = 0;
    last_due  = 0;
    notes.delete();
    i_mem.go_idle();
    @(negedge clk);
    check("ready in reset", 32'h1, 32'(op_ready));
    check("busy in reset", 32'h0, 32'(busy));
    check("retire in reset", 32'h0, 32'(retire));
    check("info in reset", 32'h0, 32'(issue_info));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    foreach (tab[i]) run(tab[i], 1'(i), i % 2);
    drain();
    end_sim();
  end

endmodule // tb_top
